// ### cri_top.v
// CPU reset acceptance and register initialization.
//
// Overview of operation
// - Program counter loads from three vector bytes.
// - Extended stack pointer initializes to 100H.
// - Interrupt mask level set to seven.
// - Wide addressing mode bit set to one.
// - Register bank pointer cleared to zero.
// - Execution starts at loaded vector after release.
// - Other CPU registers are left unchanged.
// - Peripheral I/O registers return to initial values.
// - All port pins forced to general-purpose mode.
// - Address latch strobe floats during reset.
`include "cri_defs.vh"

module cri_top #(
    parameter MIN_CLKS = `CRI_RST_MIN_CLKS
) (
    input wire CLK,
    input wire RST,
    input wire RESET_N,
    output wire [23:0] VEC_ADDR,
    output wire VEC_RD,
    input wire [7:0] VEC_DATA,
    input wire VEC_VALID,
    input wire CORE_PC_LOAD,
    input wire [23:0] CORE_PC,
    input wire CORE_SP_LOAD,
    input wire [31:0] CORE_SP,
    input wire CORE_SR_LOAD,
    input wire [2:0] CORE_IML,
    input wire CORE_WIDE,
    input wire [2:0] CORE_RFP,
    input wire CORE_ALE,
    output reg [23:0] PROGRAM_COUNTER,
    output reg [31:0] EXTENDED_STACK_POINTER,
    output reg [2:0] INTERRUPT_MASK_LEVEL,
    output reg WIDE_MODE,
    output reg [2:0] REGISTER_BANK_POINTER,
    output wire RESET_ACCEPTED,
    output wire IO_INIT,
    output wire PORT_GP_MODE,
    output wire ALE_O,
    output wire ALE_OE,
    output wire CPU_RUN,
    output reg CPU_START
);
    wire accepted;
    wire [23:0] vec;
    wire fetch_done;
    reg acc_q;
    reg kick;
    reg [1:0] state;
    wire fetch_start;

    cri_rst_filter #(
        .MIN_CLKS(MIN_CLKS),
        .CW(`CRI_RST_CNT_W)
    ) u_filter (
        .clk(CLK),
        .rst(RST),
        .reset_in_n(RESET_N),
        .accepted(accepted)
    );

    // A new acceptance restarts the vector read even if one was under way.
    assign fetch_start = kick | (accepted & ~acc_q);

    cri_vec_fetch u_fetch (
        .clk(CLK),
        .rst(RST),
        .start(fetch_start),
        .mem_addr(VEC_ADDR),
        .mem_rd(VEC_RD),
        .mem_data(VEC_DATA),
        .mem_valid(VEC_VALID),
        .vec(vec),
        .done(fetch_done)
    );

    assign RESET_ACCEPTED = accepted;
    assign IO_INIT = accepted;
    assign PORT_GP_MODE = accepted;
    assign ALE_O = CORE_ALE;
    assign ALE_OE = ~accepted & (state == `CRI_ST_RUN);
    assign CPU_RUN = (state == `CRI_ST_RUN);

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            acc_q <= 1'b1;
            kick <= 1'b1;
            state <= `CRI_ST_FETCH;
            CPU_START <= 1'b0;
        end else begin
            acc_q <= accepted;
            kick <= 1'b0;
            CPU_START <= 1'b0;
            if (fetch_start) begin
                state <= `CRI_ST_FETCH;
            end else begin
                case (state)
                    `CRI_ST_FETCH: begin
                        if (fetch_done) begin
                            state <= `CRI_ST_HOLD;
                        end
                    end
                    `CRI_ST_HOLD: begin
                        if (!accepted) begin
                            state <= `CRI_ST_RUN;
                            CPU_START <= 1'b1;
                        end
                    end
                    `CRI_ST_RUN: begin
                        state <= `CRI_ST_RUN;
                    end
                    default: begin
                        state <= `CRI_ST_FETCH;
                    end
                endcase
            end
        end
    end

    // Only the listed state is initialized; the core owns everything else.
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            PROGRAM_COUNTER <= `CRI_PC_RESET;
            EXTENDED_STACK_POINTER <= `CRI_SP_RESET;
            INTERRUPT_MASK_LEVEL <= `CRI_IML_RESET;
            WIDE_MODE <= `CRI_WIDE_RESET;
            REGISTER_BANK_POINTER <= `CRI_RFP_RESET;
        end else if (accepted || state != `CRI_ST_RUN) begin
            if (fetch_done) begin
                PROGRAM_COUNTER <= vec;
            end
            EXTENDED_STACK_POINTER <= `CRI_SP_RESET;
            INTERRUPT_MASK_LEVEL <= `CRI_IML_RESET;
            WIDE_MODE <= `CRI_WIDE_RESET;
            REGISTER_BANK_POINTER <= `CRI_RFP_RESET;
        end else begin
            if (CORE_PC_LOAD) begin
                PROGRAM_COUNTER <= CORE_PC;
            end
            if (CORE_SP_LOAD) begin
                EXTENDED_STACK_POINTER <= CORE_SP;
            end
            if (CORE_SR_LOAD) begin
                INTERRUPT_MASK_LEVEL <= CORE_IML;
                // Narrow mode does not exist, so a zero write is dropped.
                WIDE_MODE <= WIDE_MODE | CORE_WIDE;
                REGISTER_BANK_POINTER <= CORE_RFP;
            end
        end
    end
endmodule

// ### cri_defs.vh
// Constants for the CPU reset and initialization block.
`ifndef CRI_DEFS_VH
`define CRI_DEFS_VH

`define CRI_RST_MIN_CLKS 10
`define CRI_RST_CNT_W 4

`define CRI_VEC_ADDR_LO 24'hFFFF00
`define CRI_VEC_ADDR_MID 24'hFFFF01
`define CRI_VEC_ADDR_HI 24'hFFFF02

`define CRI_PC_RESET 24'h000000
`define CRI_SP_RESET 32'h00000100
`define CRI_IML_RESET 3'h7
`define CRI_WIDE_RESET 1'h1
`define CRI_RFP_RESET 3'h0

`define CRI_ST_RUN 2'h0
`define CRI_ST_FETCH 2'h1
`define CRI_ST_HOLD 2'h2

`define CRI_FB_IDLE 2'h0
`define CRI_FB_REQ 2'h1

`endif

// ### cri_rst_filter.v
// Accepts the active-low reset input after enough consecutive low samples.
`include "cri_defs.vh"

module cri_rst_filter #(
    parameter MIN_CLKS = `CRI_RST_MIN_CLKS,
    parameter CW = `CRI_RST_CNT_W
) (
    input wire clk,
    input wire rst,
    input wire reset_in_n,
    output reg accepted
);
    reg [CW-1:0] low_cnt;
    localparam [CW-1:0] MIN_C = MIN_CLKS[CW-1:0];
    localparam [CW-1:0] MIN_M1 = MIN_C - 1'b1;

    // A short glitch low resets nothing; only a full run of low samples counts.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt <= {CW{1'b0}};
            accepted <= 1'b1;
        end else if (reset_in_n) begin
            low_cnt <= {CW{1'b0}};
            accepted <= 1'b0;
        end else if (low_cnt != MIN_C) begin
            low_cnt <= low_cnt + 1'b1;
            accepted <= accepted | (low_cnt == MIN_M1);
        end
    end
endmodule

// ### cri_vec_fetch.v
// Reads the three reset vector bytes and assembles the start address.
`include "cri_defs.vh"

module cri_vec_fetch (
    input wire clk,
    input wire rst,
    input wire start,
    output reg [23:0] mem_addr,
    output reg mem_rd,
    input wire [7:0] mem_data,
    input wire mem_valid,
    output reg [23:0] vec,
    output reg done
);
    reg [1:0] idx;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_addr <= `CRI_VEC_ADDR_LO;
            mem_rd <= 1'b0;
            vec <= `CRI_PC_RESET;
            done <= 1'b0;
            idx <= 2'h0;
        end else begin
            done <= 1'b0;
            if (start) begin
                mem_addr <= `CRI_VEC_ADDR_LO;
                mem_rd <= 1'b1;
                idx <= 2'h0;
            end else if (mem_rd && mem_valid) begin
                case (idx)
                    2'h0: begin
                        vec[7:0] <= mem_data;
                        mem_addr <= `CRI_VEC_ADDR_MID;
                        idx <= 2'h1;
                    end
                    2'h1: begin
                        vec[15:8] <= mem_data;
                        mem_addr <= `CRI_VEC_ADDR_HI;
                        idx <= 2'h2;
                    end
                    default: begin
                        vec[23:16] <= mem_data;
                        mem_rd <= 1'b0;
                        done <= 1'b1;
                        idx <= 2'h0;
                    end
                endcase
            end
        end
    end
endmodule

// ### cri_vmem.sv
// Vector memory model that answers the reset vector byte reads.
module cri_vmem (
    input wire clk,
    input wire [23:0] vec,
    input wire [1:0] dly,
    input wire rd,
    input wire [23:0] addr,
    output reg valid = 1'h0,
    output wire [7:0] data
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [1:0] cnt = 2'h0;
    wire [7:0] bsel = addr[1] ? vec[23:16] : addr[0] ? vec[15:8] : vec[7:0];
    // Outside the answer cycle the lines show the inverse, so a late sample cannot match.
    assign data = valid ? bsel : ~bsel;
    always @(posedge clk) begin
        valid <= rd && !valid && cnt == dly;
        cnt <= (rd && !valid && cnt != dly) ? cnt + 2'h1 : 2'h0;
    end
endmodule

// ### cri_chk_asserts.sv
// Checker for the reset acceptance and initialization block.
module cri_chk #(parameter MIN_CLKS = 10) (
    input wire CLK,
    input wire RST,
    input wire RESET_N,
    input wire [23:0] VEC_ADDR,
    input wire VEC_RD,
    input wire VEC_VALID,
    input wire [31:0] EXTENDED_STACK_POINTER,
    input wire [2:0] INTERRUPT_MASK_LEVEL,
    input wire WIDE_MODE,
    input wire [2:0] REGISTER_BANK_POINTER,
    input wire RESET_ACCEPTED,
    input wire PORT_GP_MODE,
    input wire ALE_OE,
    input wire CPU_START
);
    // Saturates so a long low period cannot wrap back under the limit.
    reg [7:0] lows;
    always @(posedge CLK or posedge RST)
        lows <= RST ? 8'h00 : RESET_N ? 8'h00 : lows + {7'h00, lows != 8'hFF};
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_byte;
        VEC_RD && VEC_VALID && VEC_ADDR != 24'hFFFF02;
    endsequence
    a_accept_late: assert property ($rose(RESET_ACCEPTED) |-> lows >= MIN_CLKS)
        else $error("reset taken early");
    a_accept_on: assert property (lows >= MIN_CLKS |-> RESET_ACCEPTED)
        else $error("reset not taken");
    a_vec_first: assert property ($rose(VEC_RD) |-> VEC_ADDR == 24'hFFFF00)
        else $error("bad first address");
    a_vec_hold: assert property (VEC_RD && !VEC_VALID |=> VEC_RD && $stable(VEC_ADDR))
        else $error("read not held");
    a_vec_step: assert property (s_byte |=> VEC_ADDR == $past(VEC_ADDR) + 24'h000001)
        else $error("bad address step");
    a_start_regs: assert property (CPU_START |-> EXTENDED_STACK_POINTER == 32'h00000100 &&
        {INTERRUPT_MASK_LEVEL, WIDE_MODE, REGISTER_BANK_POINTER} == 7'h78)
        else $error("bad start registers");
    a_start_pulse: assert property (CPU_START |=> !CPU_START)
        else $error("start pulse too long");
    a_start_run: assert property (CPU_START |-> !RESET_ACCEPTED && !VEC_RD)
        else $error("start too soon");
    a_ale_float: assert property (RESET_ACCEPTED |-> !ALE_OE && PORT_GP_MODE)
        else $error("pins not parked");
endmodule
bind cri_top cri_chk #(.MIN_CLKS(MIN_CLKS)) u_chk (
    .CLK(CLK),
    .RST(RST),
    .RESET_N(RESET_N),
    .VEC_ADDR(VEC_ADDR),
    .VEC_RD(VEC_RD),
    .VEC_VALID(VEC_VALID),
    .EXTENDED_STACK_POINTER(EXTENDED_STACK_POINTER),
    .INTERRUPT_MASK_LEVEL(INTERRUPT_MASK_LEVEL),
    .WIDE_MODE(WIDE_MODE),
    .REGISTER_BANK_POINTER(REGISTER_BANK_POINTER),
    .RESET_ACCEPTED(RESET_ACCEPTED),
    .PORT_GP_MODE(PORT_GP_MODE),
    .ALE_OE(ALE_OE),
    .CPU_START(CPU_START)
);

// ### tb_top.sv
// Self-checking bench for the reset acceptance and initialization block.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    reg CLK = 0, RST = 1, RESET_N = 1, CORE_PC_LOAD = 0, CORE_SP_LOAD = 0;
    reg CORE_SR_LOAD = 0, CORE_WIDE = 1, CORE_ALE = 0;
    reg [23:0] CORE_PC = 0, vec = 24'hA5C3E1;
    reg [31:0] CORE_SP = 0;
    reg [2:0] CORE_IML = 0, CORE_RFP = 0;
    reg [1:0] dly = 0;
    wire [23:0] VEC_ADDR, PROGRAM_COUNTER;
    wire [31:0] EXTENDED_STACK_POINTER;
    wire [7:0] VEC_DATA;
    wire [2:0] INTERRUPT_MASK_LEVEL, REGISTER_BANK_POINTER;
    wire VEC_RD, VEC_VALID, WIDE_MODE, RESET_ACCEPTED, IO_INIT, PORT_GP_MODE;
    wire ALE_O, ALE_OE, CPU_RUN, CPU_START;
    integer n_fail = 0, comparisons = 0, i;
    always #12.5 CLK = ~CLK;
    cri_top dut (
        .CLK(CLK), .RST(RST), .RESET_N(RESET_N),
        .VEC_ADDR(VEC_ADDR), .VEC_RD(VEC_RD), .VEC_DATA(VEC_DATA), .VEC_VALID(VEC_VALID),
        .CORE_PC_LOAD(CORE_PC_LOAD), .CORE_PC(CORE_PC),
        .CORE_SP_LOAD(CORE_SP_LOAD), .CORE_SP(CORE_SP),
        .CORE_SR_LOAD(CORE_SR_LOAD), .CORE_IML(CORE_IML), .CORE_WIDE(CORE_WIDE),
        .CORE_RFP(CORE_RFP), .CORE_ALE(CORE_ALE),
        .PROGRAM_COUNTER(PROGRAM_COUNTER),
        .EXTENDED_STACK_POINTER(EXTENDED_STACK_POINTER),
        .INTERRUPT_MASK_LEVEL(INTERRUPT_MASK_LEVEL), .WIDE_MODE(WIDE_MODE),
        .REGISTER_BANK_POINTER(REGISTER_BANK_POINTER),
        .RESET_ACCEPTED(RESET_ACCEPTED), .IO_INIT(IO_INIT), .PORT_GP_MODE(PORT_GP_MODE),
        .ALE_O(ALE_O), .ALE_OE(ALE_OE), .CPU_RUN(CPU_RUN), .CPU_START(CPU_START)
    );
    cri_vmem vmem (.clk(CLK), .vec(vec), .dly(dly), .rd(VEC_RD), .addr(VEC_ADDR),
        .valid(VEC_VALID), .data(VEC_DATA));
    task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %0s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task results;
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task t_start(input [23:0] v);
        i = 0;
        while (CPU_START !== 1'h1 && i < 300) @(posedge CLK) #1 i++;
        chk(CPU_START, 1'h1, "start");
        chk(CPU_RUN, 1'h1, "run");
        chk(PROGRAM_COUNTER, v, "pc");
        chk({INTERRUPT_MASK_LEVEL, WIDE_MODE, REGISTER_BANK_POINTER}, 7'h78, "sr");
        chk(EXTENDED_STACK_POINTER, 32'h00000100, "sp");
    endtask
    // Low runs of various lengths; the vector answer delay varies with them.
    task t_pin(input integer n, input [23:0] v);
        @(negedge CLK);
        vec = v;
        dly = n[1:0];
        RESET_N = 0;
        repeat (n) @(negedge CLK);
        chk(RESET_ACCEPTED, n > 9, "acc");
        chk({IO_INIT, PORT_GP_MODE, ALE_OE}, n > 9 ? 3'h6 : 3'h1, "pins");
        RESET_N = 1;
        if (n > 9)
            t_start(v);
    endtask
    task t_core;
        @(negedge CLK);
        CORE_PC = 24'h123456;
        CORE_SP = 32'h00ABCDEF;
        {CORE_IML, CORE_WIDE, CORE_RFP} = 7'h2D;
        {CORE_PC_LOAD, CORE_SP_LOAD, CORE_SR_LOAD, CORE_ALE} = 4'hF;
        @(negedge CLK);
        {CORE_PC_LOAD, CORE_SP_LOAD, CORE_SR_LOAD} = 3'h0;
        chk({ALE_O, ALE_OE}, 2'h3, "ale");
        chk(PROGRAM_COUNTER, 24'h123456, "cpc");
        chk(EXTENDED_STACK_POINTER, 32'h00ABCDEF, "csp");
        chk({INTERRUPT_MASK_LEVEL, WIDE_MODE, REGISTER_BANK_POINTER}, 7'h2D, "csr");
    endtask
    initial begin
        repeat (10) @(negedge CLK);
        RST = 0;
        t_start(vec);
        t_core;
        t_pin(9, 24'h0F0F0F);
        chk(PROGRAM_COUNTER, 24'h123456, "keep");
        t_pin(10, 24'h3C5A96);
        t_core;
        t_pin(13, 24'hFEDCBA);
        results;
    end
    initial begin
        #20000 n_fail++;
        results;
    end
endmodule
